/* include/ccc_pkg.sv */
//============================================================
// Function
// - Free 13-bit counter wraps 0..8191; write enable from bit 9 rise.
// - Capture pulse one cycle wide every 1024 cycles, first at bin 512.
// - Capture counter cleared by final equalization sync.
// - Four capture FIFOs collect 8 bins each per window, then drain one by one.
// - Twin sample RAMs get identical writes at remapped antenna index.
// - Port A address muxed between write and read sides.
// - Lists are read only in logic; host loads them.
// - Only low 5 bits of each 32-bit list word address an antenna.
// - Processing limited to 128 auto and 128 cross entries.
// - Antenna and correlation counts set iteration lengths.
// - Engines start on falling RAM write enable; A cross, B beam/auto.
// - List pointers stepped; list values address sample RAMs.
// - Beam accumulator cleared before first input; sum one cycle later.
// - Beam output per polarization is 32-bit real, 32-bit imaginary.
// - Auto products multiply each sample by its own conjugate.
// - Cross product is first operand times conjugate of second.
// - Products quantized to 64 bits into FIFOs with empty flags.
// - Output order: auto H, auto V, cross, then two beam sums.
// - Beam slot two cycles; auto and cross slots follow counts.
// - Output mux drives 64-bit data with aligned valid strobe.
// - Word after end-of-frame is lost; size packets to whole sequences.
// - Packet length comes from a host-writable input.
//============================================================
package ccc_pkg;
  localparam int CCC_CNT_W = 13;
  localparam logic [12:0] CCC_CNT_MAX = 13'h1fff;
  localparam int CCC_EDGE_BIT = 9;
  localparam int CCC_NSTREAM = 4;
  localparam int CCC_SPS = 8;
  localparam int CCC_NANT = 32;
  localparam int CCC_ANT_W = 5;
  localparam int CCC_LIST_DEPTH = 1024;
  localparam int CCC_LIST_AW = 10;
  localparam logic [7:0] CCC_MAX_ITEMS = 8'h80;
  localparam int CCC_SMP_W = 70;
  localparam int CCC_HALF_W = 35;
  localparam int CCC_OUT_W = 64;
  localparam int CCC_Q_W = 32;
  localparam logic [1:0] CCC_BEAM_SLOTS = 2'h2;

  typedef struct packed {
    logic signed [CCC_HALF_W-1:0] re;
    logic signed [CCC_HALF_W-1:0] im;
  } ccc_cplx_t;

  typedef struct packed {
    logic valid;
    logic [CCC_OUT_W-1:0] data;
  } ccc_word_t;

  typedef enum logic [2:0] {
    CCC_IDLE, CCC_AUTO_H, CCC_AUTO_V, CCC_CROSS, CCC_BEAM
  } ccc_out_state_t;
endpackage : ccc_pkg

/* rtl/ccc_correlator.sv */
`timescale 1ns/100ps
module ccc_correlator
  import ccc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Equalized streams
  input wire logic eq_sync,
  input wire ccc_cplx_t eq_data [CCC_NSTREAM],
  // Host-loaded lists and counts
  input wire logic [31:0] list_word [4],
  output logic [CCC_LIST_AW-1:0] list_addr [4],
  input wire logic [7:0] n_ants,
  input wire logic [7:0] n_corr,
  input wire logic [15:0] pkt_len,
  // Framer side
  output ccc_word_t frm_out,
  output logic frm_eof,
  output logic [15:0] frm_len
);
  // list_word: 0 pol H, 1 pol V, 2 first operand, 3 second operand
  //============================================================
  // Capture timing
  logic [CCC_CNT_W-1:0] cnt_reg;
  logic bit_d_reg;
  logic cap_we;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      cnt_reg <= '0;
    else if (eq_sync)
      cnt_reg <= '0;
    else if (cnt_reg == CCC_CNT_MAX)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 13'h0001;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      bit_d_reg <= 1'b0;
    else
      bit_d_reg <= cnt_reg[CCC_EDGE_BIT];
  // Rising edge of the tenth bit lands on bin 512 of each spectrum
  assign cap_we = cnt_reg[CCC_EDGE_BIT] & ~bit_d_reg;

  //============================================================
  // Capture FIFOs, one per stream
  ccc_cplx_t cap_mem [CCC_NSTREAM][CCC_SPS];
  logic [2:0] cap_wp_reg;
  logic [2:0] slot_reg;
  logic cap_full_reg;
  logic drain_reg;
  logic [1:0] dr_fifo_reg;
  logic [2:0] dr_idx_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      cap_wp_reg <= '0;
      cap_full_reg <= 1'b0;
    end
    else if (cap_we && !drain_reg)
    begin
      cap_wp_reg <= cap_wp_reg + 3'h1;
      if (cap_wp_reg == 3'h7)
        cap_full_reg <= 1'b1;
    end
    else if (drain_reg)
      cap_full_reg <= 1'b0;
  always_ff @(posedge sys_clk)
    if (cap_we && !drain_reg)
      for (int s = 0; s < CCC_NSTREAM; s++)
        cap_mem[s][cap_wp_reg] <= eq_data[s];
  // FFT order 0-4-1-5-2-6-3-7 within each stream
  function automatic logic [2:0] ccc_remap(input logic [2:0] k);
    ccc_remap = {k[0], k[2:1]};
  endfunction : ccc_remap

  //============================================================
  // Twin sample RAMs
  ccc_cplx_t ram0 [CCC_NANT];
  ccc_cplx_t ram1 [CCC_NANT];
  logic ram_we;
  logic [CCC_ANT_W-1:0] wr_addr;
  logic [CCC_ANT_W-1:0] ra0_addr, ra1_addr, rb_addr;
  logic [CCC_ANT_W-1:0] port_a0, port_a1;
  assign ram_we = drain_reg;
  assign wr_addr = {dr_fifo_reg, ccc_remap(dr_idx_reg)};
  assign port_a0 = ram_we ? wr_addr : ra0_addr;
  assign port_a1 = ram_we ? wr_addr : ra1_addr;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      drain_reg <= 1'b0;
      dr_fifo_reg <= '0;
      dr_idx_reg <= '0;
    end
    else if (!drain_reg && cap_full_reg)
      drain_reg <= 1'b1;
    else if (drain_reg)
    begin
      dr_idx_reg <= dr_idx_reg + 3'h1;
      if (dr_idx_reg == 3'h7)
      begin
        dr_fifo_reg <= dr_fifo_reg + 2'h1;
        if (dr_fifo_reg == 2'h3)
          drain_reg <= 1'b0;
      end
    end
  always_ff @(posedge sys_clk)
    if (ram_we)
    begin
      ram0[port_a0] <= cap_mem[dr_fifo_reg][dr_idx_reg];
      ram1[port_a1] <= cap_mem[dr_fifo_reg][dr_idx_reg];
    end
  ccc_cplx_t xa_q, xb_q, bq_h, bq_v;
  always_ff @(posedge sys_clk)
  begin
    xa_q <= ram0[port_a0];
    xb_q <= ram1[port_a1];
    bq_h <= ram0[rb_addr];
  end

  //============================================================
  // List address generation
  logic we_d_reg;
  logic run_reg;
  logic [7:0] ptr_reg;
  logic [7:0] lim_ant, lim_cor;
  logic [1:0] ph_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      we_d_reg <= 1'b0;
    else
      we_d_reg <= ram_we;
  assign lim_ant = (n_ants > CCC_MAX_ITEMS) ? CCC_MAX_ITEMS : n_ants;
  assign lim_cor = (n_corr > CCC_MAX_ITEMS) ? CCC_MAX_ITEMS : n_corr;
  // ph 0: auto H and beam H, 1: auto V and beam V, 2: cross
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      run_reg <= 1'b0;
      ptr_reg <= '0;
      ph_reg <= '0;
    end
    else if (we_d_reg && !ram_we)
    begin
      run_reg <= 1'b1;
      ptr_reg <= '0;
      ph_reg <= '0;
    end
    else if (run_reg)
    begin
      if (ptr_reg + 8'h01 >= (ph_reg == 2'h2 ? lim_cor : lim_ant))
      begin
        ptr_reg <= '0;
        ph_reg <= ph_reg + 2'h1;
        if (ph_reg == 2'h2)
          run_reg <= 1'b0;
      end
      else
        ptr_reg <= ptr_reg + 8'h01;
    end
  // Lists are read only; no write port exists here
  always_comb
    for (int i = 0; i < 4; i++)
      list_addr[i] = {2'h0, ptr_reg};
  // Pipeline: list read 1 cycle, RAM read 1 cycle
  logic [1:0] v_pipe;
  logic [1:0] ph_p1, ph_p2;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      v_pipe <= '0;
      ph_p1 <= '0;
      ph_p2 <= '0;
    end
    else
    begin
      v_pipe <= {v_pipe[0],
                 run_reg && (ph_reg != 2'h2 ? lim_ant : lim_cor) != 8'h00};
      ph_p1 <= ph_reg;
      ph_p2 <= ph_p1;
    end
  assign rb_addr = (ph_p1 == 2'h1) ? list_word[1][CCC_ANT_W-1:0]
                                   : list_word[0][CCC_ANT_W-1:0];
  assign ra0_addr = list_word[2][CCC_ANT_W-1:0];
  assign ra1_addr = list_word[3][CCC_ANT_W-1:0];
  assign bq_v = bq_h;

  //============================================================
  // Engines
  function automatic logic [CCC_OUT_W-1:0] ccc_cmul_conj(
    input ccc_cplx_t a, input ccc_cplx_t b);
    logic signed [2*CCC_HALF_W:0] re, im;
    re = a.re * b.re + a.im * b.im;
    im = a.im * b.re - a.re * b.im;
    ccc_cmul_conj = {re[2*CCC_HALF_W-1 -: CCC_Q_W],
                     im[2*CCC_HALF_W-1 -: CCC_Q_W]};
  endfunction : ccc_cmul_conj
  logic [CCC_OUT_W-1:0] fh_mem [CCC_MAX_ITEMS];
  logic [CCC_OUT_W-1:0] fv_mem [CCC_MAX_ITEMS];
  logic [CCC_OUT_W-1:0] fx_mem [CCC_MAX_ITEMS];
  logic [7:0] wh_reg, wv_reg, wx_reg, rd_reg;
  logic signed [CCC_HALF_W+7:0] acc_re [2], acc_im [2];
  logic eng_v;
  assign eng_v = v_pipe[1];
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      wh_reg <= '0;
      wv_reg <= '0;
      wx_reg <= '0;
      for (int p = 0; p < 2; p++)
      begin
        acc_re[p] <= '0;
        acc_im[p] <= '0;
      end
    end
    else if (we_d_reg && !ram_we)
    begin
      wh_reg <= '0;
      wv_reg <= '0;
      wx_reg <= '0;
      for (int p = 0; p < 2; p++)
      begin
        acc_re[p] <= '0;
        acc_im[p] <= '0;
      end
    end
    else if (eng_v)
      unique case (ph_p2)
        2'h0, 2'h1:
        begin
          if (ph_p2 == 2'h0)
            wh_reg <= wh_reg + 8'h01;
          else
            wv_reg <= wv_reg + 8'h01;
          acc_re[ph_p2[0]] <= acc_re[ph_p2[0]] + bq_h.re;
          acc_im[ph_p2[0]] <= acc_im[ph_p2[0]] + bq_h.im;
        end
        default:
          wx_reg <= wx_reg + 8'h01;
      endcase
  always_ff @(posedge sys_clk)
    if (eng_v)
    begin
      if (ph_p2 == 2'h0)
        fh_mem[wh_reg[6:0]] <= ccc_cmul_conj(bq_h, bq_h);
      if (ph_p2 == 2'h1)
        fv_mem[wv_reg[6:0]] <= ccc_cmul_conj(bq_v, bq_v);
      if (ph_p2 == 2'h2)
        fx_mem[wx_reg[6:0]] <= ccc_cmul_conj(xa_q, xb_q);
    end
  function automatic logic [CCC_OUT_W-1:0] ccc_beam_q(
    input logic signed [CCC_HALF_W+7:0] re,
    input logic signed [CCC_HALF_W+7:0] im);
    ccc_beam_q = {re[CCC_HALF_W+7 -: CCC_Q_W],
                  im[CCC_HALF_W+7 -: CCC_Q_W]};
  endfunction : ccc_beam_q

  //============================================================
  // Output sequencer
  ccc_out_state_t st_reg;
  logic eng_done_reg;
  logic fh_empty, fv_empty, fx_empty;
  assign fh_empty = (rd_reg >= wh_reg);
  assign fv_empty = (rd_reg >= wv_reg);
  assign fx_empty = (rd_reg >= wx_reg);
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
      eng_done_reg <= 1'b0;
    else
      eng_done_reg <= ph_p1 == 2'h3 && ph_p2 == 2'h2;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      st_reg <= CCC_IDLE;
      rd_reg <= '0;
      frm_out <= '0;
    end
    else
    begin
      frm_out.valid <= 1'b0;
      unique case (st_reg)
        CCC_IDLE:
          if (eng_done_reg && (wh_reg | wv_reg | wx_reg) != 0)
          begin
            st_reg <= CCC_AUTO_H;
            rd_reg <= '0;
          end
        CCC_AUTO_H:
          if (fh_empty)
          begin
            st_reg <= CCC_AUTO_V;
            rd_reg <= '0;
          end
          else
          begin
            frm_out <= '{1'b1, fh_mem[rd_reg[6:0]]};
            rd_reg <= rd_reg + 8'h01;
          end
        CCC_AUTO_V:
          if (fv_empty)
          begin
            st_reg <= CCC_CROSS;
            rd_reg <= '0;
          end
          else
          begin
            frm_out <= '{1'b1, fv_mem[rd_reg[6:0]]};
            rd_reg <= rd_reg + 8'h01;
          end
        CCC_CROSS:
          if (fx_empty)
          begin
            st_reg <= CCC_BEAM;
            rd_reg <= '0;
          end
          else
          begin
            frm_out <= '{1'b1, fx_mem[rd_reg[6:0]]};
            rd_reg <= rd_reg + 8'h01;
          end
        CCC_BEAM:
        begin
          frm_out <= '{1'b1, ccc_beam_q(acc_re[rd_reg[0]], acc_im[rd_reg[0]])};
          rd_reg <= rd_reg + 8'h01;
          if (rd_reg + 8'h01 == {6'h00, CCC_BEAM_SLOTS})
          begin
            st_reg <= CCC_IDLE;
            rd_reg <= '0;
          end
        end
      endcase
    end

  //============================================================
  // Framer length and end-of-frame
  logic [15:0] wcnt_reg;
  always_ff @(posedge sys_clk or posedge rst)
    if (rst)
    begin
      wcnt_reg <= '0;
      frm_eof <= 1'b0;
      frm_len <= '0;
    end
    else
    begin
      frm_len <= pkt_len;
      frm_eof <= 1'b0;
      if (frm_out.valid)
      begin
        if (wcnt_reg + 16'h0001 >= pkt_len)
        begin
          wcnt_reg <= '0;
          frm_eof <= 1'b1;
        end
        else
          wcnt_reg <= wcnt_reg + 16'h0001;
      end
    end
endmodule : ccc_correlator

/* test/ccc_checker_sva.sv */
`timescale 1ns/100ps
//============================================================
// Port checker
module ccc_checker
  import ccc_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Watched ports
  input wire logic eq_sync,
  input wire logic [CCC_LIST_AW-1:0] list_addr [4],
  input wire logic [15:0] pkt_len,
  input wire ccc_word_t frm_out,
  input wire logic frm_eof,
  input wire logic [15:0] frm_len
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [8:0] words_reg;
  logic [3:0] gap_reg;
  //============================================================
  // Words per burst
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      words_reg <= 9'h0;
      gap_reg <= 4'h0;
    end
    else if (frm_out.valid)
    begin
      words_reg <= words_reg + 9'h1;
      gap_reg <= 4'h0;
    end
    else if (gap_reg != 4'hf)
      gap_reg <= gap_reg + 4'h1;
    else
      words_reg <= 9'h0;
  end
  //============================================================
  // Properties
  sequence s_sync_quiet;
    ##1 !frm_out.valid [*8];
  endsequence
  sequence s_eof_done;
    frm_eof ##1 !frm_eof;
  endsequence
  a_len_copy: assert property ($past(!rst) |->
    frm_len == $past(pkt_len))
    else $error("packet length not copied");
  a_addr_equal: assert property (list_addr[0] == list_addr[1] &&
    list_addr[0] == list_addr[2] && list_addr[0] == list_addr[3])
    else $error("list pointers differ");
  a_addr_limit: assert property (list_addr[0] <= 10'h080)
    else $error("list pointer past limit");
  a_eof_pulse: assert property (frm_eof |-> s_eof_done)
    else $error("end of frame longer than one cycle");
  a_eof_word: assert property ($rose(frm_eof) |->
    $past(frm_out.valid) || $past(frm_out.valid, 2))
    else $error("end of frame without a word");
  a_sync_quiet: assert property (eq_sync |-> s_sync_quiet)
    else $error("output right after sync");
  a_burst_limit: assert property (frm_out.valid |-> words_reg < 9'h182)
    else $error("burst too long");
  a_data_held: assert property (!frm_out.valid && $past(!rst) |->
    $stable(frm_out.data))
    else $error("data moved without valid");
endmodule : ccc_checker

bind ccc_correlator ccc_checker u_chk (.sys_clk(sys_clk), .rst(rst),
  .eq_sync(eq_sync), .list_addr(list_addr), .pkt_len(pkt_len),
  .frm_out(frm_out), .frm_eof(frm_eof), .frm_len(frm_len));

/* test/ccc_list_model.sv */
`timescale 1ns/100ps
//============================================================
// Host-loaded list memories
module ccc_list_model
  import ccc_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Read port
  input wire logic [CCC_LIST_AW-1:0] list_addr [4],
  output logic [31:0] list_word [4]
);
  logic [31:0] mem [4][CCC_LIST_DEPTH];
  // Host side only writes
  task automatic load(input int l, input int i, input logic [31:0] w);
    mem[l][i] = w;
  endtask : load
  always_ff @(posedge sys_clk)
  begin
    for (int l = 0; l < 4; l++)
      list_word[l] <= mem[l][list_addr[l]];
  end
endmodule : ccc_list_model

/* test/testbench.sv */
`timescale 1ns/100ps
`define CHECK(got, exp, msg) \
  begin \
    n_tests++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("unexpected at %0t: %s", $time, msg); \
    end \
  end
//============================================================
// Bench top
module testbench;
  import ccc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic eq_sync = 1'b0;
  ccc_cplx_t eq_data [CCC_NSTREAM];
  ccc_cplx_t smp;
  logic [31:0] list_word [4];
  logic [CCC_LIST_AW-1:0] list_addr [4];
  logic [7:0] n_ants = 8'h0;
  logic [7:0] n_corr = 8'h0;
  logic [15:0] pkt_len = 16'h0;
  ccc_word_t frm_out;
  logic frm_eof;
  logic [15:0] frm_len;
  int n_fail = 0;
  int n_tests = 0;

  ccc_correlator dut (.sys_clk(sys_clk), .rst(rst), .eq_sync(eq_sync),
    .eq_data(eq_data), .list_word(list_word), .list_addr(list_addr),
    .n_ants(n_ants), .n_corr(n_corr), .pkt_len(pkt_len),
    .frm_out(frm_out), .frm_eof(frm_eof), .frm_len(frm_len));
  ccc_list_model lists (.sys_clk(sys_clk), .list_addr(list_addr),
    .list_word(list_word));

  initial
  begin
    forever #2 sys_clk = ~sys_clk;
  end
  //============================================================
  // Helpers
  function automatic int clamp(input int n);
    return (n > 128) ? 128 : n;
  endfunction : clamp
  // Auto and cross power of one sample, top 32 bits
  function automatic logic [31:0] exp_pow(input ccc_cplx_t v);
    logic signed [70:0] p;
    p = v.re * v.re + v.im * v.im;
    return p[69:38];
  endfunction : exp_pow
  // Beam sum of n equal samples, top 32 bits
  function automatic logic [31:0] exp_beam(input int n,
    input logic signed [34:0] v);
    logic signed [42:0] s;
    s = 43'(n) * v;
    return s[42:11];
  endfunction : exp_beam
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask : step
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // One result burst
  task automatic run_window(input int na, input int nc);
    int tot;
    int nw;
    int k;
    int idle;
    int eofs;
    ccc_word_t w [$];
    logic [63:0] bexp;
    nw = 2 * clamp(na) + clamp(nc);
    bexp = {exp_beam(clamp(na), smp.re), exp_beam(clamp(na), smp.im)};
    tot = nw + 2;
    step();
    n_ants = 8'(na);
    n_corr = 8'(nc);
    pkt_len = 16'(tot);
    k = 0;
    idle = 0;
    eofs = 0;
    while (frm_out.valid !== 1'b1 || k > 20000)
    begin
      if (k > 20000)
      begin
        n_fail++;
        report_and_stop();
      end
      step();
      k++;
    end
    while (idle < 16 && w.size() < 1000)
    begin
      if (frm_out.valid === 1'b1)
        w.push_back(frm_out);
      idle = (frm_out.valid === 1'b1) ? 0 : idle + 1;
      if (frm_eof === 1'b1)
        eofs++;
      step();
    end
    `CHECK(w.size(), tot, "word count")
    foreach (w[i])
    begin
      if (i < nw)
      begin
        `CHECK(w[i].data[31:0], 32'h0, "product imag")
        `CHECK(w[i].data[63], 1'b0, "product sign")
        `CHECK(w[i].data[63:32], exp_pow(smp), "product real")
      end
      else
      begin
        `CHECK(w[i].data[63], smp.re[34], "beam re sign")
        `CHECK(w[i].data[31], smp.im[34], "beam im sign")
        `CHECK(w[i].data, bexp, "beam value")
      end
    end
    `CHECK(eofs, 1, "eof count")
    `CHECK(frm_len, 16'(tot), "length copy")
    $display("window %0d/%0d done", na, nc);
  endtask : run_window
  //============================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'h5fc26406));
    smp.re = 35'(signed'($urandom | 32'h1));
    smp.im = 35'(signed'($urandom | 32'h1));
    foreach (eq_data[s])
      eq_data[s] = smp;
    for (int l = 0; l < 4; l++)
      for (int i = 0; i < 128; i++)
        lists.load(l, i, $urandom);
    repeat (4) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    step();
    eq_sync = 1'b1;
    step();
    eq_sync = 1'b0;
    run_window(9, 8);
    run_window(1 + $urandom % 40, 1 + $urandom % 60);
    run_window(200, 255);
    report_and_stop();
  end
endmodule : testbench
